//--- common/sild_pkg.sv
/*
  shared constants for the serial-in latched output driver and its host.
  assumes the host runs on clk_sys at 125 MHz and derives the shift clock.
*/
package sild_pkg;
  localparam int N_STAGES             = 10;
  localparam int CLK_PERIOD_NS        = 8;
  localparam int CLOCK_HIGH_WIDTH_NS  = 50;
  localparam int LATCH_PULSE_WIDTH_NS = 50;
  localparam int CLOCK_TO_LATCH_GAP_NS = 100;
  localparam int FIFO_DEPTH           = 8;
  // least times round up to whole cycles
  localparam int CLOCK_HIGH_CYC  =
    (CLOCK_HIGH_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_PULSE_CYC =
    (LATCH_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_GAP_CYC   =
    (CLOCK_TO_LATCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;
  localparam logic [N_STAGES-1:0] STAGE_RESET = 10'h000;

  typedef enum logic [2:0] {
    SILD_IDLE   = 3'b000,
    SILD_LOW    = 3'b001,
    SILD_HIGH   = 3'b010,
    SILD_GAP    = 3'b011,
    SILD_STROBE = 3'b100
  } sild_state_e;
endpackage

//--- common/sild_if.sv
/*
  link between host and driver: shift clock, serial data, latch load,
  output blank and cascade output. assumes both ends sit in one bench.
*/
`timescale 1ns/100ps
interface sild_if;
  logic shift_clk;    // shift clock, made by the host
  logic serial_data;  // serial data into stage one
  logic latch_load;   // latches transparent while high
  logic output_blank; // all outputs low while high
  logic cascade_out;  // last stage, for chaining

  modport dev (
    input  shift_clk,
    input  serial_data,
    input  latch_load,
    input  output_blank,
    output cascade_out
  );
  modport host (
    output shift_clk,
    output serial_data,
    output latch_load,
    output output_blank,
    input  cascade_out
  );
endinterface

//--- verilog/sild_device.sv
/*
  driver end: ten shift stages on the link clock, level latches and
  blanked outputs. assumes the host keeps the link timing.
*/
`timescale 1ns/100ps
module sild_device #(
  parameter int N = sild_pkg::N_STAGES
) (
  input  wire logic rst_n,        // async reset, active low
  sild_if.dev       link,         // link to the host
  output logic [N-1:0] drive_out  // parallel driver outputs
);
  logic [N-1:0] stage; // ten stages, one latch and output each [R1]
  logic [N-1:0] latch_q;

  // stage[0] is the first stage; stage[N-1] feeds the cascade
  always_ff @(posedge link.shift_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= sild_pkg::STAGE_RESET;
    end else begin
      stage <= {stage[N-2:0], link.serial_data}; // [R2] [R3]
    end
  end

  assign link.cascade_out = stage[N-1]; // [R3]

  // real level latches: follow the stages while load is high, hold else
  always_latch begin
    if (!rst_n) begin
      latch_q = sild_pkg::STAGE_RESET;
    end else if (link.latch_load) begin
      latch_q = stage; // [R4]
    end
  end
  // load low: no assignment, latch holds [R5]; blank never touches it [R8]

  // outputs are combinational on purpose: blanking must not wait a clock
  assign drive_out = link.output_blank ? '0 : latch_q; // [R7] [R9]
endmodule

//--- verilog/sild_host.sv
/*
  host end: word FIFO, shift clock divider and latch load sequencer.
  assumes one clk_sys domain; the shift clock it drives feeds the driver.
*/
// Functional notes
// R1: driver holds ten stages, latches, outputs
// R2: rising shift clock captures serial data
// R3: each edge shifts toward cascade output; the driver shifts on rising edges only
// R4: load high makes latches follow stages
// R5: load low keeps latch contents
// R6: bypassed latches need blank during shifting
// R7: blank high forces every output low
// R8: blank leaves latch contents untouched
// R9: unblanked outputs follow their latches
// R10: wait 100 ns after clock before load
// R11: load pulse at least 50 ns
// R12: clock high phase at least 50 ns
`timescale 1ns/100ps
module sild_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input  wire logic         clk_sys,   // system clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic [W-1:0] in_data,   // word to store
  input  wire logic         in_valid,  // word offered
  output logic              in_ready,  // room for a word
  output logic [W-1:0]      out_data,  // oldest word
  output logic              out_valid, // a word is held
  input  wire logic         out_ready  // drain takes the word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          do_wr;
  logic          do_rd;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module sild_host #(
  parameter int N     = sild_pkg::N_STAGES,
  parameter int DEPTH = sild_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_sys,     // system clock, 125 MHz
  input  wire logic         rst_n,       // async reset, active low
  sild_if.host              link,        // link to the driver
  input  wire logic [N-1:0] word_data,   // pattern for the outputs
  input  wire logic         word_valid,  // pattern offered
  output logic              word_ready,  // pattern accepted
  input  wire logic         blank_req,   // blank all outputs
  input  wire logic         bypass_mode, // hold latch load high
  output logic              busy,        // a word is in flight
  output logic              cascade_in   // synchronised cascade bit
);
  localparam logic [sild_pkg::CNT_W-1:0] HIGH_LAST =
    sild_pkg::CNT_W'(sild_pkg::CLOCK_HIGH_CYC - 1);
  localparam logic [sild_pkg::CNT_W-1:0] GAP_LAST =
    sild_pkg::CNT_W'(sild_pkg::LATCH_GAP_CYC - 1);
  localparam logic [sild_pkg::CNT_W-1:0] PULSE_LAST =
    sild_pkg::CNT_W'(sild_pkg::LATCH_PULSE_CYC - 1);
  localparam logic [sild_pkg::CNT_W-1:0] LAST_BIT =
    sild_pkg::CNT_W'(N - 1);

  sild_pkg::sild_state_e state;
  logic [sild_pkg::CNT_W-1:0] cnt;
  logic [sild_pkg::CNT_W-1:0] bit_idx;
  logic [N-1:0]               shreg;
  logic [N-1:0]               fifo_data;
  logic                       fifo_valid;
  logic                       fifo_pop;
  logic                       sclk;
  logic                       sdata;
  logic                       load;
  logic                       blank;
  logic                       casc_meta;
  logic                       casc_sync;

  // the FIFO fills while a word is shifting; word_ready is its honest room
  sild_fifo #(
    .W (N),
    .D (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign fifo_pop = (state == sild_pkg::SILD_IDLE) && fifo_valid;

  // sequencer: shift the word out msb first so bit N-1 lands in the
  // far stage, then wait and pulse the latch load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= sild_pkg::SILD_IDLE;
      cnt     <= '0;
      bit_idx <= '0;
      shreg   <= sild_pkg::STAGE_RESET;
      sclk    <= 1'b0;
      sdata   <= 1'b0;
      load    <= 1'b0;
    end else begin
      case (state)
        sild_pkg::SILD_IDLE: begin
          load <= 1'b0;
          if (fifo_valid) begin
            shreg   <= {fifo_data[N-2:0], 1'b0};
            sdata   <= fifo_data[N-1];
            bit_idx <= '0;
            cnt     <= HIGH_LAST;
            state   <= sild_pkg::SILD_LOW;
          end
        end
        sild_pkg::SILD_LOW: begin
          // low phase as long as high one gives set-up margin too
          if (cnt == '0) begin
            sclk  <= 1'b1;
            cnt   <= HIGH_LAST;
            state <= sild_pkg::SILD_HIGH;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        sild_pkg::SILD_HIGH: begin
          if (cnt == '0) begin // [R12]
            sclk <= 1'b0;
            if (bit_idx == LAST_BIT) begin
              cnt   <= GAP_LAST;
              state <= sild_pkg::SILD_GAP;
            end else begin
              // data changes on the falling edge: hold and set-up both met
              sdata   <= shreg[N-1];
              shreg   <= {shreg[N-2:0], 1'b0};
              bit_idx <= bit_idx + 1'b1;
              cnt     <= HIGH_LAST;
              state   <= sild_pkg::SILD_LOW;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        sild_pkg::SILD_GAP: begin
          if (cnt == '0) begin // [R10]
            load  <= 1'b1;
            cnt   <= PULSE_LAST;
            state <= sild_pkg::SILD_STROBE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        sild_pkg::SILD_STROBE: begin
          if (cnt == '0) begin // [R11]
            load  <= 1'b0;
            state <= sild_pkg::SILD_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= sild_pkg::SILD_IDLE;
          sclk  <= 1'b0;
          load  <= 1'b0;
        end
      endcase
    end
  end

  // outputs registered so the pins never glitch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.latch_load   <= 1'b0;
      link.output_blank <= 1'b1;
      busy              <= 1'b0;
    end else begin
      link.latch_load   <= load || bypass_mode;
      // bypassed latches would show the data rippling past, so blank it
      link.output_blank <= blank_req ||
                           (bypass_mode && (blank || fifo_pop)); // [R6]
      busy              <= fifo_pop || (state != sild_pkg::SILD_IDLE);
    end
  end

  always_comb begin
    blank = (state == sild_pkg::SILD_LOW) ||
            (state == sild_pkg::SILD_HIGH) ||
            (state == sild_pkg::SILD_GAP);
  end

  assign link.shift_clk   = sclk;
  assign link.serial_data = sdata;

  // cascade bit comes from the driver's clock domain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      casc_meta  <= 1'b0;
      casc_sync  <= 1'b0;
      cascade_in <= 1'b0;
    end else begin
      casc_meta  <= link.cascade_out;
      casc_sync  <= casc_meta;
      cascade_in <= casc_sync;
    end
  end
endmodule

//--- bench/sild_chk.sv
/*
  assertions on the host-driver link and the driver outputs.
  assumes link signals are registers of the clk_sys domain.
*/
`timescale 1ns/100ps
module sild_chk (
  input wire logic       clk_sys,      // system clock
  input wire logic       rst_n,        // reset, active low
  input wire logic       shift_clk,    // shift clock
  input wire logic       serial_data,  // serial data
  input wire logic       latch_load,   // latch load
  input wire logic       output_blank, // output blank
  input wire logic       cascade_out,  // last stage
  input wire logic [9:0] drive_out     // driver outputs
);
  logic [9:0] sh;
  logic [9:0] lat;
  logic [3:0] low_cnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // shadow stages lag the driver by one cycle after each rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sh <= 10'h000;
    else if ($rose(shift_clk)) sh <= {sh[8:0], serial_data};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) lat <= 10'h000;
    else if (latch_load) lat <= sh;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) low_cnt <= 4'hF;
    else if (shift_clk) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  end

  sequence s_clk_high;
    shift_clk [*7];
  endsequence
  sequence s_load_high;
    latch_load [*7];
  endsequence

  a_blank_all_low: assert property (
    output_blank |-> drive_out == 10'h000) else $error("blank leak");
  a_cascade_last: assert property (
    $rose(shift_clk) |-> cascade_out == sh[8]) else $error("cascade");
  a_latch_follow: assert property (
    latch_load && !output_blank && $stable(shift_clk) |-> drive_out == sh)
    else $error("latch not following");
  a_latch_hold: assert property (
    !latch_load && !$past(latch_load) && !output_blank
    && !$past(output_blank) |-> $stable(drive_out)) else $error("hold");
  a_unblank_drive: assert property (
    !output_blank && !latch_load |-> drive_out == lat)
    else $error("outputs differ from latches");
  a_clk_high_width: assert property (
    $rose(shift_clk) |-> s_clk_high) else $error("short clock high");
  a_load_width: assert property (
    $rose(latch_load) |-> s_load_high) else $error("short load");
  a_load_gap: assert property (
    $rose(latch_load) |-> low_cnt >= 4'hD) else $error("load too early");
  a_bypass_blank: assert property (
    latch_load && $rose(shift_clk) |-> output_blank)
    else $error("shift while bypassed and unblanked");
endmodule

//--- bench/tb.sv
/*
  top bench: host and driver joined by the link, checker beside it.
  assumes the host makes the shift clock from clk_sys.
*/
`timescale 1ns/100ps
module tb;
  logic       clk_sys;
  logic       rst_n;
  logic [9:0] word_data;
  logic       word_valid;
  logic       word_ready;
  logic       blank_req;
  logic       bypass_mode;
  logic       busy;
  logic       cascade_in;
  logic [9:0] drive_out;
  int         error_cnt;
  int         checked;

  sild_if sild_if_inst ();
  sild_host sild_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(sild_if_inst), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .blank_req(blank_req),
    .bypass_mode(bypass_mode), .busy(busy), .cascade_in(cascade_in));
  sild_device sild_device_inst (.rst_n(rst_n), .link(sild_if_inst),
    .drive_out(drive_out));
  sild_chk sild_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .shift_clk(sild_if_inst.shift_clk),
    .serial_data(sild_if_inst.serial_data),
    .latch_load(sild_if_inst.latch_load),
    .output_blank(sild_if_inst.output_blank),
    .cascade_out(sild_if_inst.cascade_out), .drive_out(drive_out));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // entered at a falling edge; returns one edge after the take
  task automatic offer(input logic [9:0] w);
    word_data = w;
    word_valid = 1'b1;
    while (!word_ready) @(negedge clk_sys);
    @(negedge clk_sys);
    word_valid = 1'b0;
  endtask

  // old pattern must stand until the latch pulse of the new frame
  task automatic frame(input logic [9:0] w, input logic [9:0] prev);
    logic [9:0] exp;
    int         n;
    exp = prev;
    n = 0;
    offer(w);
    repeat (2) @(negedge clk_sys);
    while (busy && n < 400) begin
      if (n > 20 && sild_if_inst.latch_load && !sild_if_inst.output_blank)
        exp = w;
      cmp(drive_out, sild_if_inst.output_blank ? 10'h000 : exp);
      n++;
      @(negedge clk_sys);
    end
    // a frame that never finishes counts against the run
    cmp({9'h000, busy}, 10'h000);
    cmp(drive_out, w);
    cmp({9'h000, cascade_in}, {9'h000, w[9]});
  endtask

  task automatic t_basic;
    frame(10'h2A5, 10'h000);
    frame(10'h15A, 10'h2A5);
  endtask

  task automatic t_blank;
    blank_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp(drive_out, 10'h000);
    blank_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    cmp(drive_out, 10'h15A);
  endtask

  task automatic t_bypass;
    bypass_mode = 1'b1;
    repeat (3) @(negedge clk_sys);
    frame(10'h0F0, 10'h15A);
    bypass_mode = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  // a full buffer refuses the extra word; the last taken one wins
  task automatic t_fill;
    int n;
    int m;
    n = 0;
    m = 0;
    word_data = 10'h100;
    word_valid = 1'b1;
    while (word_ready && n < 20) begin
      n++;
      @(negedge clk_sys);
      word_data = 10'h100 + 10'(n);
    end
    @(negedge clk_sys);
    word_valid = 1'b0;
    cmp(10'(n), 10'(sild_pkg::FIFO_DEPTH + 1));
    while (m < 40) begin
      @(negedge clk_sys);
      m = busy ? 0 : m + 1;
    end
    cmp(drive_out, 10'h100 + 10'(n - 1));
  endtask

  initial begin
    rst_n = 1'b0;
    word_data = 10'h000;
    word_valid = 1'b0;
    blank_req = 1'b0;
    bypass_mode = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    cmp(drive_out, 10'h000);
    t_basic;
    t_blank;
    t_bypass;
    t_fill;
    complete_run;
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    complete_run;
  end
endmodule
